/* iwu_map.vh */
`ifndef IWU_MAP_VH
`define IWU_MAP_VH

// interrupt control register bit positions
`define IWU_GIE_BIT      7
`define IWU_NVIE_BIT     6
`define IWU_TOIE_BIT     5
`define IWU_EXT_PIN_IRQ_ENABLE_BIT     4
`define IWU_PORT_CHANGE_ENABLE_BIT     3
`define IWU_TOIF_BIT     2
`define IWU_EXT_PIN_IRQ_FLAG_BIT     1
`define IWU_PORT_CHANGE_FLAG_BIT     0

// reset values
`define IWU_CTRL_POR     8'h00
`define IWU_CTRL_KEEP    8'h01
`define IWU_VECTOR_POR   13'h0000

// interrupt vector
`define IWU_IRQ_VECTOR   13'h0004

// watchdog timing
`define IWU_WDT_TIMEOUT_US  18000
`define IWU_WDT_OSC_KHZ     1000
`define IWU_KHZ_PER_MHZ     1000
`define IWU_PRESC_ONE       8'h01

`endif

/* iwu_wdog.v */
`timescale 1ns/1ns
`include "iwu_map.vh"

module iwu_wdog #(
   parameter BASE_TICKS = 18000,
   parameter CW         = 20
) (
   // clock and reset
   input  wire          clk,
   input  wire          rst,
   // control
   input  wire          tick,
   input  wire          enable,
   input  wire          presc_sel,
   input  wire [2:0]    presc_rate,
   input  wire          clear,
   // event
   output reg           timeout_pulse
);

   reg  [6:0]    presc_q;
   reg  [CW-1:0] base_q;

   // terminal count of prescaler: 1:1 when not assigned, else 1:2^rate
   function [6:0] presc_limit;
      input       sel;
      input [2:0] rate;
      reg   [7:0] full;
      begin
         full        = (`IWU_PRESC_ONE << rate) - `IWU_PRESC_ONE;
         presc_limit = sel ? full[6:0] : 7'h00;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // prescaler and base counter advance on oscillator ticks only
   always @(posedge clk) begin
      if (rst || clear || !enable) begin
         presc_q       <= 7'h00;
         base_q        <= {CW{1'b0}};
         timeout_pulse <= 1'b0;
      end else begin
         timeout_pulse <= 1'b0;
         if (tick) begin
            if (presc_q >= presc_limit(presc_sel, presc_rate)) begin
               presc_q <= 7'h00;
               if (base_q == BASE_TICKS[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
                  base_q        <= {CW{1'b0}};
                  timeout_pulse <= 1'b1;
               end else begin
                  base_q <= base_q + {{(CW-1){1'b0}}, 1'b1};
               end
            end else begin
               presc_q <= presc_q + 7'h01;
            end
         end
      end
   end

endmodule // iwu_wdog

/* iwu_top.v */
// Contract
// - TO/PD encode cause: 11 por/run reset, 01 wdt reset, 00 wdt wake, 10 sleep reset/irq
// - global enable bit 7 passes unmasked interrupts when set, blocks all when clear
// - every reset clears the global enable
// - return-from-interrupt sets the global enable again
// - accepted interrupt clears global enable, pushes return, loads vector 0004h
// - pin and port-change events reach the vector in three to four cycles
// - flags set on their event regardless of any enable
// - external pin edge selected by option bit sets flag bit 1
// - external interrupt masked by bit 4; wakes sleep only when enabled
// - timer wrap sets flag bit 2, gated by enable bit 5
// - change on upper port-B nibble sets flag bit 0, enable bit 3
// - a change coinciding with a port-B read still sets flag bit 0
// - only the return address is saved on interrupt entry
// - interrupt during a global-enable clear returns with enable set; software loops
// - watchdog runs from its own oscillator, also during sleep
// - watchdog timeout resets when running, wakes when sleeping
// - configuration bit at zero disables the watchdog
// - nominal 18 ms timeout, extended by prescaler up to 1:128
// - clear-watchdog and sleep reset counter and prescaler
// - each watchdog timeout clears the timeout status bit
// - sleep clears watchdog, clears powerdown bit, sets timeout bit, stops oscillator
// - enabled interrupt wakes sleep; vector after next instruction only if enabled
`timescale 1ns/1ns
`include "iwu_map.vh"

module iwu_top #(
   parameter WDT_OSC_KHZ    = `IWU_WDT_OSC_KHZ,
   parameter WDT_BASE_TICKS = `IWU_WDT_TIMEOUT_US * WDT_OSC_KHZ / `IWU_KHZ_PER_MHZ,
   parameter WDT_CW         = 20
) (
   // clock and reset
   input  wire          MCLK_IN,
   input  wire          RESET_IN,
   // pins
   input  wire          EXT_IRQ_PIN_IN,
   input  wire [3:0]    PORT_B_PINS_IN,
   input  wire          EXTERNAL_RESET_PIN_N_IN,
   input  wire          WDT_OSC_IN,
   // core events
   input  wire          INSTR_BOUNDARY_IN,
   input  wire          RETURN_FROM_IRQ_INSTR_IN,
   input  wire          CLEAR_WATCHDOG_INSTR_IN,
   input  wire          SLEEP_INSTR_IN,
   input  wire          PORT_B_READ_IN,
   // peripheral events
   input  wire          MAIN_TIMER_WRAP_IN,
   input  wire          NV_WRITE_DONE_FLAG_IN,
   // control register write port
   input  wire          IRQ_CONTROL_WE_IN,
   input  wire [7:0]    IRQ_CONTROL_WDATA_IN,
   // options and configuration
   input  wire          EXT_EDGE_SELECT_IN,
   input  wire          PRESC_TO_WATCHDOG_IN,
   input  wire [2:0]    PRESC_RATE_IN,
   input  wire          WATCHDOG_ENABLE_CFG_IN,
   // status
   output wire [7:0]    IRQ_CONTROL_REG_OUT,
   output wire          TIMEOUT_STATUS_N_OUT,
   output wire          POWERDOWN_STATUS_N_OUT,
   output wire          SLEEPING_OUT,
   // to the core
   output wire          IRQ_REQ_OUT,
   output wire          CORE_RESET_OUT,
   output wire          WAKE_OUT,
   output wire          STACK_PUSH_OUT,
   output wire          VECTOR_LOAD_OUT,
   output wire [12:0]   VECTOR_OUT
);

   reg           ext_s1_q, ext_s2_q, ext_prev_q;
   reg  [3:0]    pb_s1_q, pb_s2_q, pb_ref_q;
   reg           osc_s1_q, osc_s2_q, osc_prev_q;
   reg           rst_s1_q, rst_s2_q;
   reg  [7:0]    ctrl_q, ctrl_d;
   reg           to_q, pd_q;
   reg           sleep_q;
   reg           core_rst_q, wake_q, push_q, load_q;
   reg  [12:0]   vector_q;
   wire          ext_edge;
   wire          pb_change;
   wire          osc_tick;
   wire          ext_rst;
   wire          wdt_timeout;
   wire          irq_pending;
   wire          irq_req;
   wire          take;
   wire          sleep_go;
   wire          wdt_reset;
   wire          wdt_wake;

   ////////////////////////////////////////////////////////////////////////////
   // overview of the event flow, for whoever picks this block up next
   //
   // pins: the pin, the port nibble, the reset pin and the watchdog
   // oscillator all enter through two flops; nothing reads the first stage.
   // the cost is two cycles of latency on every pin event, which the
   // three-to-four instruction cycle latency budget easily absorbs.
   //
   // flags: each flag bit is set by its event whatever the enables say.
   // only a reset or a control write clears a flag, and a
   // set arriving in the same cycle as that write still wins, so no event
   // is lost to a software clear racing the hardware.
   //
   // request: the core sees a plain level, flags and enables combined. the
   // take itself is only honoured on an instruction boundary, so the core
   // never gets redirected in the middle of an instruction.
   //
   // sleep: a sleep with an enabled flag already pending is a no-op and
   // leaves the watchdog and status bits alone; software can tell by the
   // powerdown bit still being set.
   //
   // watchdog: its oscillator is far slower than the core clock, so one
   // rising edge of the synchronised signal is one tick. a timeout while
   // awake is a one-cycle core reset; while asleep it is a wake pulse.
   //
   // status: the external reset pin may be held for many cycles; the cause
   // is decided at its first cycle and then held until the pin is released.

   ////////////////////////////////////////////////////////////////////////////
   // two-stage synchronisers on every pin, history taken off the second stage
   always @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         ext_s1_q   <= 1'b0;
         ext_s2_q   <= 1'b0;
         ext_prev_q <= 1'b0;
         pb_s1_q    <= 4'h0;
         pb_s2_q    <= 4'h0;
         osc_s1_q   <= 1'b0;
         osc_s2_q   <= 1'b0;
         osc_prev_q <= 1'b0;
         rst_s1_q   <= 1'b1;
         rst_s2_q   <= 1'b1;
      end else begin
         ext_s1_q   <= EXT_IRQ_PIN_IN;
         ext_s2_q   <= ext_s1_q;
         ext_prev_q <= ext_s2_q;
         pb_s1_q    <= PORT_B_PINS_IN;
         pb_s2_q    <= pb_s1_q;
         osc_s1_q   <= WDT_OSC_IN;
         osc_s2_q   <= osc_s1_q;
         osc_prev_q <= osc_s2_q;
         rst_s1_q   <= EXTERNAL_RESET_PIN_N_IN;
         rst_s2_q   <= rst_s1_q;
      end
   end

   // edge chosen by the option bit
   assign ext_edge  = EXT_EDGE_SELECT_IN ? (ext_s2_q & ~ext_prev_q)
                                         : (~ext_s2_q & ext_prev_q);
   assign pb_change = (pb_s2_q != pb_ref_q);
   assign osc_tick  = osc_s2_q & ~osc_prev_q;
   assign ext_rst   = ~rst_s2_q;

   ////////////////////////////////////////////////////////////////////////////
   // port-b reference latch: a read reloads it; a change landing in the
   // same cycle as the read still sets flag bit 0 at that same edge
   always @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         pb_ref_q <= 4'h0;
      end else if (PORT_B_READ_IN) begin
         pb_ref_q <= pb_s2_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog, counting synchronised oscillator ticks
   iwu_wdog #(
      .BASE_TICKS    (WDT_BASE_TICKS),
      .CW            (WDT_CW)
   ) u_wdog (
      .clk           (MCLK_IN),
      .rst           (RESET_IN | ext_rst),
      .tick          (osc_tick),
      .enable        (WATCHDOG_ENABLE_CFG_IN),
      .presc_sel     (PRESC_TO_WATCHDOG_IN),
      .presc_rate    (PRESC_RATE_IN),
      .clear         (CLEAR_WATCHDOG_INSTR_IN | sleep_go),
      .timeout_pulse (wdt_timeout)
   );

   assign wdt_reset = wdt_timeout & ~sleep_q;
   assign wdt_wake  = wdt_timeout & sleep_q;

   ////////////////////////////////////////////////////////////////////////////
   // request: flags gated by their enables, then by the global enable
   assign irq_pending = (ctrl_q[`IWU_EXT_PIN_IRQ_FLAG_BIT] & ctrl_q[`IWU_EXT_PIN_IRQ_ENABLE_BIT])
                      | (ctrl_q[`IWU_TOIF_BIT] & ctrl_q[`IWU_TOIE_BIT])
                      | (ctrl_q[`IWU_PORT_CHANGE_FLAG_BIT] & ctrl_q[`IWU_PORT_CHANGE_ENABLE_BIT])
                      | (NV_WRITE_DONE_FLAG_IN & ctrl_q[`IWU_NVIE_BIT]);
   assign irq_req  = irq_pending & ctrl_q[`IWU_GIE_BIT];
   // sampled only at an instruction boundary while awake
   assign take     = irq_req & INSTR_BOUNDARY_IN & ~sleep_q & ~core_rst_q;
   // a pending enabled source turns sleep into a no-op
   assign sleep_go = SLEEP_INSTR_IN & ~irq_pending & ~sleep_q;

   ////////////////////////////////////////////////////////////////////////////
   // next control value; hardware sets always win over a software write
   always @* begin
      ctrl_d = IRQ_CONTROL_WE_IN ? IRQ_CONTROL_WDATA_IN : ctrl_q;
      if (take) begin
         ctrl_d[`IWU_GIE_BIT] = 1'b0;
      end
      if (RETURN_FROM_IRQ_INSTR_IN) begin
         ctrl_d[`IWU_GIE_BIT] = 1'b1;
      end
      if (ext_edge) begin
         ctrl_d[`IWU_EXT_PIN_IRQ_FLAG_BIT] = 1'b1;
      end
      if (MAIN_TIMER_WRAP_IN) begin
         ctrl_d[`IWU_TOIF_BIT] = 1'b1;
      end
      if (pb_change) begin
         ctrl_d[`IWU_PORT_CHANGE_FLAG_BIT] = 1'b1;
      end
      if (ext_rst || wdt_reset) begin
         ctrl_d = ctrl_q & `IWU_CTRL_KEEP;
      end
   end

   // control register
   always @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         ctrl_q <= `IWU_CTRL_POR;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset-cause status bits and sleep state
   always @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         to_q    <= 1'b1;
         pd_q    <= 1'b1;
         sleep_q <= 1'b0;
      end else if (ext_rst) begin
         to_q    <= 1'b1;
         // a held pin keeps the cause from its first cycle, else a reset
         // taken during sleep would turn into a run-time one a cycle later
         pd_q    <= core_rst_q ? pd_q : ~sleep_q;
         sleep_q <= 1'b0;
      end else if (wdt_timeout) begin
         to_q    <= 1'b0;
         pd_q    <= ~sleep_q;
         sleep_q <= 1'b0;
      end else if (sleep_go) begin
         to_q    <= 1'b1;
         pd_q    <= 1'b0;
         sleep_q <= 1'b1;
      end else if (sleep_q && irq_pending) begin
         sleep_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core strobes; only the return address goes to the stack, nothing else
   always @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         core_rst_q <= 1'b1;
         wake_q     <= 1'b0;
         push_q     <= 1'b0;
         load_q     <= 1'b0;
         vector_q   <= `IWU_VECTOR_POR;
      end else begin
         core_rst_q <= ext_rst | wdt_reset;
         wake_q     <= wdt_wake | (sleep_q & irq_pending & ~ext_rst);
         push_q     <= take;
         load_q     <= take;
         if (take) begin
            vector_q <= `IWU_IRQ_VECTOR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign IRQ_CONTROL_REG_OUT    = ctrl_q;
   assign TIMEOUT_STATUS_N_OUT   = to_q;
   assign POWERDOWN_STATUS_N_OUT = pd_q;
   assign SLEEPING_OUT           = sleep_q;   // core gates its oscillator on this
   assign IRQ_REQ_OUT            = irq_req;
   assign CORE_RESET_OUT         = core_rst_q;
   assign WAKE_OUT               = wake_q;
   assign STACK_PUSH_OUT         = push_q;
   assign VECTOR_LOAD_OUT        = load_q;
   assign VECTOR_OUT             = vector_q;

endmodule // iwu_top

/* iwu_checker.sv */
`timescale 1ns/1ns
module iwu_checker (
   // watched ports of the top module
   input wire MCLK_IN, RESET_IN, EXT_IRQ_PIN_IN, EXTERNAL_RESET_PIN_N_IN,
   input wire INSTR_BOUNDARY_IN, RETURN_FROM_IRQ_INSTR_IN, SLEEP_INSTR_IN,
   input wire MAIN_TIMER_WRAP_IN, NV_WRITE_DONE_FLAG_IN, EXT_EDGE_SELECT_IN,
   input wire WATCHDOG_ENABLE_CFG_IN, TIMEOUT_STATUS_N_OUT, POWERDOWN_STATUS_N_OUT,
   input wire SLEEPING_OUT, IRQ_REQ_OUT, CORE_RESET_OUT, WAKE_OUT,
   input wire STACK_PUSH_OUT, VECTOR_LOAD_OUT,
   input wire [7:0] IRQ_CONTROL_REG_OUT,
   input wire [12:0] VECTOR_OUT
);
   // enabled pending sources; nv flag is an outside level on enable bit 6
   wire [7:0] c    = IRQ_CONTROL_REG_OUT;
   wire       pend = |(c[6:3] & {NV_WRITE_DONE_FLAG_IN, c[2:0]});
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (RESET_IN);
   sequence s_take;
      INSTR_BOUNDARY_IN && IRQ_REQ_OUT && !SLEEPING_OUT && !CORE_RESET_OUT;
   endsequence
   sequence s_edge;
      EXT_EDGE_SELECT_IN ? $rose(EXT_IRQ_PIN_IN) : $fell(EXT_IRQ_PIN_IN);
   endsequence
   AST_REQ_GATE:
      assert property (IRQ_REQ_OUT == (c[7] && pend)) else $error("request gating wrong");
   AST_TAKE:
      assert property (s_take and !RETURN_FROM_IRQ_INSTR_IN |=> STACK_PUSH_OUT && !c[7])
      else $error("interrupt not taken");
   AST_VECTOR:
      assert property (VECTOR_LOAD_OUT |-> VECTOR_OUT == 13'h0004 && STACK_PUSH_OUT)
      else $error("vector or push wrong");
   AST_NO_SPURIOUS:
      assert property (STACK_PUSH_OUT |-> $past(INSTR_BOUNDARY_IN) && $past(IRQ_REQ_OUT))
      else $error("push without request");
   AST_RETURN:
      assert property (RETURN_FROM_IRQ_INSTR_IN && !CORE_RESET_OUT && EXTERNAL_RESET_PIN_N_IN
         |=> c[7]) else $error("return left enable clear");
   AST_TIMER_FLAG:
      assert property (MAIN_TIMER_WRAP_IN && !CORE_RESET_OUT |=> c[2] || CORE_RESET_OUT)
      else $error("timer flag missed");
   AST_EXT_FLAG:
      assert property (s_edge |-> ##[1:5] c[1]) else $error("pin flag missed");
   AST_SLEEP:
      assert property (SLEEP_INSTR_IN && !SLEEPING_OUT && !pend && !CORE_RESET_OUT
         |=> SLEEPING_OUT && !POWERDOWN_STATUS_N_OUT && TIMEOUT_STATUS_N_OUT)
      else $error("sleep entry wrong");
   AST_SLEEP_NOP:
      assert property (SLEEP_INSTR_IN && !SLEEPING_OUT && pend
         |=> !SLEEPING_OUT && $stable(POWERDOWN_STATUS_N_OUT)) else $error("sleep not a nop");
   AST_WAKE:
      assert property ($fell(SLEEPING_OUT) |-> ##[0:2] (WAKE_OUT || CORE_RESET_OUT))
      else $error("left sleep without cause");
   AST_TIMEOUT:
      assert property ($fell(TIMEOUT_STATUS_N_OUT) |-> ##[0:1] (WAKE_OUT || CORE_RESET_OUT))
      else $error("timeout without action");
   AST_WDT_OFF:
      assert property (!WATCHDOG_ENABLE_CFG_IN && $past(WATCHDOG_ENABLE_CFG_IN, 4) == 1'b0
         |-> !$fell(TIMEOUT_STATUS_N_OUT)) else $error("disabled watchdog fired");
   AST_WAKE_PULSE:
      assert property (WAKE_OUT |=> !WAKE_OUT) else $error("wake not a pulse");
endmodule // iwu_checker
bind iwu_top iwu_checker iwu_checker_inst (.*);

/* iwu_core_model.sv */
`timescale 1ns/1ns
module iwu_core_model (
   input  wire       clk, push_in,
   input  wire [7:0] ctrl_in,
   output reg        boundary_out, we_out, return_from_irq_instr_out,
   output reg  [7:0] wdata_out, isr_n
);
   reg [1:0] ph_q = 2'h0;
   reg [4:0] isr_q = 5'h00;
   initial {boundary_out, we_out, return_from_irq_instr_out, wdata_out, isr_n} = 19'h0;
   // four clocks an instruction; a short service routine after each push
   always @(negedge clk) begin
      ph_q <= ph_q + 2'h1;
      boundary_out <= (ph_q == 2'h3);
      we_out <= 1'b0;
      return_from_irq_instr_out <= 1'b0;
      if (push_in) begin
         isr_q <= 5'h10;
         isr_n <= isr_n + 8'h01;
      end else if (isr_q != 5'h00) isr_q <= isr_q - 5'h01;
      // flags cleared before leaving, else the request repeats forever
      if (isr_q == 5'h08) begin
         we_out <= 1'b1;
         wdata_out <= {1'b0, ctrl_in[6:3], 3'h0};
      end
      if (isr_q == 5'h02) return_from_irq_instr_out <= 1'b1;
   end
endmodule // iwu_core_model

/* iwu_top_tb.sv */
`timescale 1ns/1ns
module iwu_top_tb;
   reg clk, rst, pin, nrst, osc, clrw, slp, rd, wrap, we, esel, psel, wcfg;
   reg [3:0] pb;
   reg [7:0] wd;
   wire [7:0] ctrl, md, isr_n;
   wire [12:0] vec;
   wire to_n, pd_n, sl, rq, crst, wk, push, ld, bnd, mwe, ret;
   integer num_errors, checked, i, n, rs, ocnt;
   integer t [0:1];
   iwu_top #(.WDT_BASE_TICKS(8)) iwu_top_inst (.MCLK_IN(clk), .RESET_IN(rst),
      .EXT_IRQ_PIN_IN(pin), .PORT_B_PINS_IN(pb), .EXTERNAL_RESET_PIN_N_IN(nrst),
      .WDT_OSC_IN(osc), .INSTR_BOUNDARY_IN(bnd), .RETURN_FROM_IRQ_INSTR_IN(ret),
      .CLEAR_WATCHDOG_INSTR_IN(clrw), .SLEEP_INSTR_IN(slp), .PORT_B_READ_IN(rd),
      .MAIN_TIMER_WRAP_IN(wrap), .NV_WRITE_DONE_FLAG_IN(1'b0), .IRQ_CONTROL_WE_IN(we | mwe),
      .IRQ_CONTROL_WDATA_IN(mwe ? md : wd), .EXT_EDGE_SELECT_IN(esel),
      .PRESC_TO_WATCHDOG_IN(psel), .PRESC_RATE_IN(3'h1), .WATCHDOG_ENABLE_CFG_IN(wcfg),
      .IRQ_CONTROL_REG_OUT(ctrl), .TIMEOUT_STATUS_N_OUT(to_n), .POWERDOWN_STATUS_N_OUT(pd_n),
      .SLEEPING_OUT(sl), .IRQ_REQ_OUT(rq), .CORE_RESET_OUT(crst), .WAKE_OUT(wk),
      .STACK_PUSH_OUT(push), .VECTOR_LOAD_OUT(ld), .VECTOR_OUT(vec));
   iwu_core_model iwu_core_model_inst (.clk(clk), .push_in(push), .ctrl_in(ctrl),
      .boundary_out(bnd), .we_out(mwe), .return_from_irq_instr_out(ret), .wdata_out(md), .isr_n(isr_n));
   ////////////////////////////////////////////////////////////////////////////////
   // 50 MHz clock; watchdog oscillator far slower so a timeout is a few dozen cycles
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(negedge clk) begin
      ocnt = ocnt + 1;
      if (ocnt % 3 == 0) osc = ~osc;
   end
   always @(posedge clk) if (crst === 1'b1) rs = rs + 1;
   task step(input integer k); repeat (k) @(negedge clk); endtask
   task chk(input [7:0] e, input [7:0] g); begin
      checked = checked + 1;
      if (e !== g) begin
         num_errors = num_errors + 1;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   end endtask
   task chkb(input e, input g); chk({7'h0, e}, {7'h0, g}); endtask
   task wr(input [7:0] d); begin wd = d; we = 1'b1; step(1); we = 1'b0; step(1); end endtask
   // one-cycle instruction and event pulses
   task pls(input [1:0] k); begin
      case (k) 0: slp = 1'b1; 1: clrw = 1'b1; 2: rd = 1'b1; default: wrap = 1'b1; endcase
      step(1);
      {slp, clrw, rd, wrap} = 4'h0;
   end endtask
   // bounded wait on wake, core reset or stack push
   task wt(input [1:0] k, output integer c); begin
      c = 0;
      while ((k == 0 ? wk : k == 1 ? crst : push) !== 1'b1 && c < 400) begin
         step(1);
         c = c + 1;
      end
      if (c >= 400) begin num_errors = num_errors + 1; report_and_stop; end
   end endtask
   task report_and_stop; begin
      if (num_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, pin, osc, clrw, slp, rd, wrap, we, esel, psel, wcfg} = 11'h400;
      nrst = 1'b1; pb = 4'h0; wd = 8'h00;
      num_errors = 0; checked = 0; rs = 0; ocnt = 0;
      step(10); rst = 1'b0; step(4);
      chk(8'h00, ctrl);
      chkb(1'b1, to_n); chkb(1'b1, pd_n);
      pls(3); chk(8'h04, ctrl); chkb(1'b0, rq);
      pb = 4'h9; step(4); chk(8'h05, ctrl);
      pls(2); wr(8'h00); chk(8'h00, ctrl);
      // both edges under both selections; only the selected one counts
      for (i = 0; i < 4; i = i + 1) begin
         esel = i[1]; step(1); pin = ~pin; step(6);
         chkb(pin == esel, ctrl[1]);
         wr(8'h00);
      end
      esel = 1'b1; wr(8'h90); pin = 1'b1; wt(2, n);
      chkb(1'b1, n <= 16);
      chk(8'h04, vec[7:0]); chkb(1'b0, ctrl[7]);
      chkb(1'b1, ld);
      step(30); chk(8'h90, ctrl); chk(8'h01, isr_n);
      esel = 1'b0; wr(8'h10); pls(0);
      chkb(1'b1, sl); chkb(1'b1, to_n); chkb(1'b0, pd_n);
      pin = 1'b0; wt(0, n); chkb(1'b0, sl);
      step(8); chk(8'h12, ctrl); chk(8'h01, isr_n);
      pls(0); chkb(1'b0, sl);
      wr(8'h00); wcfg = 1'b1; pls(1); pls(0);
      wt(0, n); chkb(1'b0, to_n); chkb(1'b0, pd_n);
      rs = 0;
      repeat (10) begin step(20); pls(1); end
      chkb(1'b0, rs > 0);
      for (i = 0; i < 2; i = i + 1) begin
         psel = i[0]; pls(1); wt(1, n); t[i] = n;
         step(4); chkb(1'b0, to_n); chkb(1'b1, pd_n);
      end
      chkb(1'b1, 2 * t[1] > 3 * t[0]);
      wcfg = 1'b0; step(6); pls(0); step(150); chkb(1'b1, sl);
      nrst = 1'b0; step(5); nrst = 1'b1; step(6);
      chkb(1'b1, to_n); chkb(1'b0, pd_n);
      wr(8'h80); nrst = 1'b0; step(5); nrst = 1'b1; step(6);
      chk(8'h00, ctrl); chkb(1'b1, to_n); chkb(1'b1, pd_n);
      report_and_stop;
   end
endmodule // iwu_top_tb
